// *** verilog/tdmcs_top.sv ***
// Multichannel selection for a TDM serial port: registers over AXI4-Lite, receive gating
// into a two-entry buffer and transmit drive/consume decisions per element slot.
// Assumes element strobes and frame syncs are synchronous to clk_sys_in.
`timescale 1ns/1ns
`default_nettype none
module tdmcs_top
    import tdmcs_pkg::*;
#(
    parameter int ELEM_W = 32
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // AXI4-Lite write channels.
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels.
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Received elements from the deserialiser.
    input wire logic rx_frame_sync_in,
    input wire logic [ELEM_W-1:0] rx_elem_data_in,
    input wire logic rx_elem_valid_in,
    output logic rx_elem_ready_out,
    // Selected received elements.
    output logic [ELEM_W-1:0] rx_data_out,
    output logic rx_data_valid_out,
    input wire logic rx_data_ready_in,
    // Transmit slot control.
    input wire logic tx_frame_active_in,
    input wire logic tx_frame_sync_in,
    input wire logic tx_elem_start_in,
    output logic serial_data_out_oe_out,
    output logic tx_elem_take_out
);
    logic rst_meta;
    logic rst_n;
    logic [31:0] ctl;
    logic [31:0] rce;
    logic [31:0] xce;
    logic [31:0] next_ctl;
    logic [31:0] next_rce;
    logic [31:0] next_xce;
    logic aw_got, w_got, next_aw_got, next_w_got;
    logic [31:0] awaddr_q, next_awaddr_q, wdata_q, next_wdata_q;
    logic [3:0] wstrb_q, next_wstrb_q;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic awready, next_awready, wready, next_wready, arready, next_arready;
    logic [31:0] rdata, next_rdata, byte_en, ctl_view;
    logic [6:0] rx_idx, next_rx_idx, tx_idx, next_tx_idx, rx_ch, tx_ch;
    logic [2:0] rx_cur, next_rx_cur, tx_cur, next_tx_cur;
    logic oe, next_oe, take, next_take;
    logic rx_hs, rx_take, wide, tx_sel, rx_sel_tx, rx_part_tx;
    tdmcs_tx_mode_e tx_mode;

    tdmcs_stream_if #(.WIDTH(ELEM_W)) fill_if ();
    tdmcs_stream_if #(.WIDTH(ELEM_W)) drain_if ();

    // Reset is released through two flops so every flop leaves reset on the same edge.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Control view: stored fields plus both live subframe indicators.
    always_comb begin
        ctl_view = ctl;
        ctl_view[TDMCS_RX_CUR_LSB +: 3] = rx_cur;
        ctl_view[TDMCS_TX_CUR_LSB +: 3] = tx_cur;
        byte_en = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    end

    // Bus slave: address and data are taken in either order, one write and one read at a time.
    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_ctl = ctl;
        next_rce = rce;
        next_xce = xce;
        if (s_axi_awvalid_in && awready) begin
            next_aw_got = 1'b1;
            next_awaddr_q = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready) begin
            next_w_got = 1'b1;
            next_wdata_q = s_axi_wdata_in;
            next_wstrb_q = s_axi_wstrb_in;
        end
        if (aw_got && w_got && !bvalid) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = TDMCS_RESP_OKAY;
            unique case (awaddr_q)
                TDMCS_OFF_CTL: next_ctl = ((ctl & ~byte_en) | (wdata_q & byte_en))
                                          & TDMCS_CTL_WR_MASK;
                TDMCS_OFF_RCE: next_rce = (rce & ~byte_en) | (wdata_q & byte_en);
                TDMCS_OFF_XCE: next_xce = (xce & ~byte_en) | (wdata_q & byte_en);
                default: next_bresp = TDMCS_RESP_SLVERR;
            endcase
        end else if (bvalid && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && arready) begin
            next_rvalid = 1'b1;
            next_rresp = TDMCS_RESP_OKAY;
            unique case (s_axi_araddr_in)
                TDMCS_OFF_CTL: next_rdata = ctl_view;
                TDMCS_OFF_RCE: next_rdata = rce;
                TDMCS_OFF_XCE: next_rdata = xce;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = TDMCS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Bus and register flops.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= TDMCS_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= TDMCS_RESP_OKAY;
            rdata <= 32'h0000_0000;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            ctl <= TDMCS_CTL_RESET;
            rce <= TDMCS_RCE_RESET;
            xce <= TDMCS_XCE_RESET;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            ctl <= next_ctl;
            rce <= next_rce;
            xce <= next_xce;
        end
    end

    // The wide range only applies when both directions ask for it, keeping them consistent.
    assign wide = ctl[TDMCS_RX_WIDE_BIT] && ctl[TDMCS_TX_WIDE_BIT];
    assign tx_mode = tdmcs_tx_mode_e'(ctl[TDMCS_TX_MODE_LSB +: 2]);

    // Receive gating: index restarts at the frame sync, unselected elements are dropped.
    always_comb begin
        rx_hs = rx_elem_valid_in && rx_elem_ready_out;
        rx_ch = rx_frame_sync_in ? TDMCS_CHAN_FIRST : rx_idx;
        rx_take = !ctl[TDMCS_RX_SEL_EN_BIT]
                  || tdmcs_chan_sel(rx_ch, ctl[TDMCS_RX_EVEN_LSB +: 2],
                                    ctl[TDMCS_RX_ODD_LSB +: 2], rce, wide);
        next_rx_idx = rx_hs ? rx_ch + 7'h01 : rx_idx;
        next_rx_cur = rx_hs ? rx_ch[6:4] : rx_cur;
    end

    // Transmit decision per slot: drive the pin and consume a word as the mode says.
    always_comb begin
        tx_ch = tx_frame_sync_in ? TDMCS_CHAN_FIRST : tx_idx;
        tx_sel = tdmcs_chan_sel(tx_ch, ctl[TDMCS_TX_EVEN_LSB +: 2],
                                ctl[TDMCS_TX_ODD_LSB +: 2], xce, wide);
        rx_sel_tx = tdmcs_chan_sel(tx_ch, ctl[TDMCS_RX_EVEN_LSB +: 2],
                                   ctl[TDMCS_RX_ODD_LSB +: 2], rce, wide);
        rx_part_tx = tdmcs_chan_sel(tx_ch, ctl[TDMCS_RX_EVEN_LSB +: 2],
                                    ctl[TDMCS_RX_ODD_LSB +: 2], xce, wide);
        next_oe = oe;
        next_take = 1'b0;
        next_tx_idx = tx_idx;
        next_tx_cur = tx_cur;
        if (tx_elem_start_in) begin
            next_tx_idx = tx_ch + 7'h01;
            next_tx_cur = tx_ch[6:4];
            unique case (tx_mode)
                TDMCS_TX_ALL: begin
                    next_oe = 1'b1;
                    next_take = 1'b1;
                end
                TDMCS_TX_SELECTED: begin
                    next_oe = tx_sel;
                    next_take = tx_sel;
                end
                TDMCS_TX_MASKED: begin
                    next_oe = tx_sel;
                    next_take = 1'b1;
                end
                TDMCS_TX_SYMMETRIC: begin
                    next_oe = rx_sel_tx && rx_part_tx;
                    next_take = rx_sel_tx;
                end
            endcase
        end
        if (!tx_frame_active_in) begin
            next_oe = 1'b0;
        end
    end

    // Channel counters and transmit outputs.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_idx <= TDMCS_CHAN_FIRST;
            rx_cur <= TDMCS_SUB_FIRST;
            tx_idx <= TDMCS_CHAN_FIRST;
            tx_cur <= TDMCS_SUB_FIRST;
            oe <= 1'b0;
            take <= 1'b0;
        end else begin
            rx_idx <= next_rx_idx;
            rx_cur <= next_rx_cur;
            tx_idx <= next_tx_idx;
            tx_cur <= next_tx_cur;
            oe <= next_oe;
            take <= next_take;
        end
    end

    // A stall downstream fills the buffer and its ready holds off the deserialiser.
    assign fill_if.data = rx_elem_data_in;
    assign fill_if.valid = rx_elem_valid_in && rx_take;
    assign drain_if.ready = rx_data_ready_in;

    tdmcs_buffer #(.WIDTH(ELEM_W)) u_buffer (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .fill(fill_if),
        .drain(drain_if)
    );

    // Outputs, all straight from flops.
    assign s_axi_awready_out = awready;
    assign s_axi_wready_out = wready;
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_arready_out = arready;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rresp_out = rresp;
    assign s_axi_rdata_out = rdata;
    assign rx_elem_ready_out = fill_if.ready;
    assign rx_data_out = drain_if.data;
    assign rx_data_valid_out = drain_if.valid;
    assign serial_data_out_oe_out = oe;
    assign tx_elem_take_out = take;

    property p_ctl_reserved_zero;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (s_axi_arvalid_in && arready && s_axi_araddr_in == TDMCS_OFF_CTL)
            |=> (rdata[15:10] == 6'h00 && rdata[1] == 1'b0 && rdata[31:26] == 6'h00);
    endproperty
    a_ctl_reserved_zero: assert property (p_ctl_reserved_zero) else $error("reserved bit set");

    property p_rx_all_when_off;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rx_hs && !ctl[0]) |-> fill_if.valid;
    endproperty
    a_rx_all_when_off: assert property (p_rx_all_when_off) else $error("element dropped");

    property p_rx_even_mask;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rx_hs && ctl[0] && !rx_ch[4] && !rce[rx_ch[3:0]]) |-> !fill_if.valid;
    endproperty
    a_rx_even_mask: assert property (p_rx_even_mask) else $error("masked even taken");

    property p_rx_odd_pick;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rx_hs && ctl[0] && rx_ch[4] && rx_ch[6:5] == ctl[8:7] && rce[{1'b1, rx_ch[3:0]}])
            |-> fill_if.valid;
    endproperty
    a_rx_odd_pick: assert property (p_rx_odd_pick) else $error("odd channel lost");

    property p_rx_index;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rx_hs && rx_frame_sync_in) |=> (rx_idx == 7'h01 && rx_cur == 3'h0);
    endproperty
    a_rx_index: assert property (p_rx_index) else $error("index not restarted");

    property p_rx_cur;
        @(posedge clk_sys_in) disable iff (!rst_n)
        rx_hs |=> ctl_view[4:2] == $past(rx_ch[6:4]);
    endproperty
    a_rx_cur: assert property (p_rx_cur) else $error("current subframe wrong");

    property p_tx_all;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (tx_elem_start_in && tx_frame_active_in && ctl[17:16] == 2'h0)
            |=> (serial_data_out_oe_out && tx_elem_take_out);
    endproperty
    a_tx_all: assert property (p_tx_all) else $error("mode 0 not driving");

    property p_tx_odd_mask;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (tx_elem_start_in && ctl[17:16] == 2'h1 && tx_ch[4] && !xce[{1'b1, tx_ch[3:0]}])
            |=> (!serial_data_out_oe_out && !tx_elem_take_out);
    endproperty
    a_tx_odd_mask: assert property (p_tx_odd_mask) else $error("masked odd driven");

    property p_tx_masked_take;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (tx_elem_start_in && ctl[17:16] == 2'h2)
            |=> tx_elem_take_out ##1 (!tx_elem_take_out || $past(tx_elem_start_in));
    endproperty
    a_tx_masked_take: assert property (p_tx_masked_take) else $error("mode 2 take wrong");
endmodule
`default_nettype wire

// *** verilog/tdmcs_pkg.sv ***
// Constants, register map and the channel selection function of the TDM channel selector.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package tdmcs_pkg;

    // Register byte offsets.
    localparam logic [31:0] TDMCS_OFF_CTL = 32'h0000_0000;
    localparam logic [31:0] TDMCS_OFF_RCE = 32'h0000_0004;
    localparam logic [31:0] TDMCS_OFF_XCE = 32'h0000_0008;

    // Field positions of the multichannel control register.
    localparam int TDMCS_RX_SEL_EN_BIT = 0;
    localparam int TDMCS_RX_CUR_LSB = 2;
    localparam int TDMCS_RX_EVEN_LSB = 5;
    localparam int TDMCS_RX_ODD_LSB = 7;
    localparam int TDMCS_RX_WIDE_BIT = 9;
    localparam int TDMCS_TX_MODE_LSB = 16;
    localparam int TDMCS_TX_CUR_LSB = 18;
    localparam int TDMCS_TX_EVEN_LSB = 21;
    localparam int TDMCS_TX_ODD_LSB = 23;
    localparam int TDMCS_TX_WIDE_BIT = 25;

    // Bits that software may store; reserved and status bits are not held.
    localparam logic [31:0] TDMCS_CTL_WR_MASK = 32'h03E3_03E1;

    // Values after reset.
    localparam logic [31:0] TDMCS_CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] TDMCS_RCE_RESET = 32'h0000_0000;
    localparam logic [31:0] TDMCS_XCE_RESET = 32'h0000_0000;
    localparam logic [6:0] TDMCS_CHAN_FIRST = 7'h00;
    localparam logic [2:0] TDMCS_SUB_FIRST = 3'h0;

    // AXI responses.
    localparam logic [1:0] TDMCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TDMCS_RESP_SLVERR = 2'h2;

    // Transmit channel selection modes.
    typedef enum logic [1:0] {
        TDMCS_TX_ALL,
        TDMCS_TX_SELECTED,
        TDMCS_TX_MASKED,
        TDMCS_TX_SYMMETRIC
    } tdmcs_tx_mode_e;

    // True when channel ch falls in a chosen subframe (any subframe when wide is set) and its mask bit is set.
    // Even subframes use the low mask half, odd subframes the high half.
    function automatic logic tdmcs_chan_sel(input logic [6:0] ch, input logic [1:0] even_sel,
                                            input logic [1:0] odd_sel, input logic [31:0] mask,
                                            input logic wide);
        logic hit;
        hit = wide || (ch[4] ? (ch[6:5] == odd_sel) : (ch[6:5] == even_sel));
        return hit && mask[{ch[4], ch[3:0]}];
    endfunction

endpackage

// *** verilog/tdmcs_stream_if.sv ***
// Valid/ready stream carrier between the selector and its element buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface tdmcs_stream_if #(parameter int WIDTH = 32);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport sink (input data, input valid, output ready);
    modport source (output data, output valid, input ready);
endinterface
`default_nettype wire

// *** verilog/tdmcs_buffer.sv ***
// Two-entry element buffer with valid and ready on both sides.
// Assumes an active-low reset, asserted asynchronously, whose release the caller has already synchronised.
`timescale 1ns/1ns
`default_nettype none
module tdmcs_buffer
    import tdmcs_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Stream ports.
    tdmcs_stream_if.sink fill,
    tdmcs_stream_if.source drain
);
    logic [WIDTH-1:0] entry0;
    logic [WIDTH-1:0] entry1;
    logic [1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] next_entry0;
    logic [WIDTH-1:0] next_entry1;
    logic [1:0] next_count;
    logic push;
    logic pop;

    assign fill.ready = in_ready;
    assign drain.valid = out_valid;
    assign drain.data = entry0;

    // Next entries; ready and valid come from flops so no path runs straight through.
    always_comb begin
        push = fill.valid && in_ready;
        pop = out_valid && drain.ready;
        next_entry0 = entry0;
        next_entry1 = entry1;
        next_count = count;
        if (push && !pop) begin
            if (count == 2'h0) begin
                next_entry0 = fill.data;
            end else begin
                next_entry1 = fill.data;
            end
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_entry0 = entry1;
            next_count = count - 2'h1;
        end else if (push && pop) begin
            next_entry0 = fill.data;
        end
    end

    // Registers of the buffer.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            entry0 <= '0;
            entry1 <= '0;
            count <= 2'h0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            entry0 <= next_entry0;
            entry1 <= next_entry1;
            count <= next_count;
            in_ready <= (next_count != 2'h2);
            out_valid <= (next_count != 2'h0);
        end
    end
endmodule
`default_nettype wire

// *** testbench/tdmcs_far_end.sv ***
// Far-end TDM device model: one frame of receive elements and paced transmit slots.
// Assumes go_in is a one-cycle pulse given between frames.
`timescale 1ns/1ns
`default_nettype none
module tdmcs_far_end (
    // Clock and control.
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic slow_in,
    // Receive element source.
    output logic rx_sync_out,
    output logic [31:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // Transmit slot pacing.
    output logic tx_sync_out,
    output logic tx_start_out
);
    logic [7:0] rc = 8'h80;
    logic [7:0] tc = 8'h80;
    logic t = 1'h0;
    // Between frames the data lines show the inverted pattern, so no stale word looks valid.
    assign rx_data_out = {24'hC35A96, rc} ^ {32{rc[7]}};
    assign rx_valid_out = !rc[7];
    assign rx_sync_out = rc == 8'h00;
    assign tx_start_out = !tc[7] && t;
    assign tx_sync_out = tx_start_out && tc == 8'h00;
    // Counters advance per handshake or slot; slow mode leaves a gap after each slot.
    always @(posedge clk_in) begin
        t <= slow_in ? !t : 1'h1;
        if (go_in) begin
            rc <= 8'h00;
            tc <= 8'h00;
        end else begin
            if (rx_valid_out && rx_ready_in) rc <= rc + 8'h01;
            if (tx_start_out) tc <= tc + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** testbench/tdm_channel_select_bench.sv ***
// Bench for the TDM channel selector: registers, receive gating and slot decisions.
// Assumes the far-end model supplies the element streams and slot pulses.
`timescale 1ns/1ns
`default_nettype none
module tdm_channel_select_bench;
    import tdmcs_pkg::*;
    localparam logic [31:0] XM = 32'h0F0F_A55A;
    localparam logic [31:0] RM = 32'h3C96_F00F;
    logic clk_sys_in = 1'h0;
    logic resetn_in = 1'h0;
    logic [31:0] s_axi_awaddr_in = 32'h0, s_axi_wdata_in = 32'h0, s_axi_araddr_in = 32'h0;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_arvalid_in = 1'h0;
    logic s_axi_bready_in = 1'h1, s_axi_rready_in = 1'h1, rx_data_ready_in = 1'h0;
    logic tx_frame_active_in = 1'h0, go = 1'h0, slow = 1'h0, st_q = 1'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, rx_frame_sync_in, rx_elem_valid_in, rx_elem_ready_out;
    logic rx_data_valid_out, tx_frame_sync_in, tx_elem_start_in;
    logic serial_data_out_oe_out, tx_elem_take_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out, rx_elem_data_in, rx_data_out, rd;
    logic [31:0] got[$], txg[$];
    int failures = 0, compares = 0, cyc = 0;
    always #10 clk_sys_in = !clk_sys_in;
    // The sink stalls two cycles in five so the two-entry buffer fills and refuses.
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        rx_data_ready_in <= (cyc % 5) > 1;
        if (rx_data_valid_out === 1'h1 && rx_data_ready_in) got.push_back(rx_data_out);
        if (st_q) txg.push_back({30'h0, serial_data_out_oe_out, tx_elem_take_out});
        st_q <= tx_elem_start_in;
    end
    tdmcs_top dut_u (.*);
    tdmcs_far_end far_u (.clk_in(clk_sys_in), .go_in(go), .slow_in(slow),
        .rx_sync_out(rx_frame_sync_in), .rx_data_out(rx_elem_data_in),
        .rx_valid_out(rx_elem_valid_in), .rx_ready_in(rx_elem_ready_out),
        .tx_sync_out(tx_frame_sync_in), .tx_start_out(tx_elem_start_in));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) failures++;
        if (g !== e) $display("Error at %0t: got %h expected %h", $time, g, e);
    endtask
    task automatic wrap_up;
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Every bus and frame wait runs through here, so a hang ends in the closing report.
    task automatic tick(inout int n);
        @(posedge clk_sys_in);
        n++;
        if (n > 3000) failures++;
        if (n > 3000) wrap_up();
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
        int n = 0;
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_awvalid_in, s_axi_wvalid_in} <= {a, d, 2'h3};
        do begin
            tick(n);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (!s_axi_bvalid_out);
        check(s_axi_bresp_out, e);
    endtask
    task automatic axr(input logic [31:0] a, input logic [31:0] x, input logic [1:0] e);
        int n = 0;
        {s_axi_araddr_in, s_axi_arvalid_in} <= {a, 1'h1};
        do begin
            tick(n);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
        end while (!s_axi_rvalid_out);
        rd = s_axi_rdata_out;
        check(s_axi_rresp_out, e);
        check(rd, x);
    endtask
    function automatic logic pick(input int c, input logic [1:0] ev, input logic [1:0] od,
                                  input logic [31:0] m, input logic w);
        return (w || ((c / 16) % 2 ? 2'(c / 32) == od : 2'(c / 32) == ev)) && m[c % 32];
    endfunction
    // One frame both ways; waits until the buffer and the slot monitor are empty.
    task automatic frame(input logic s);
        int n = 0;
        got.delete();
        txg.delete();
        {go, slow} <= {1'h1, s};
        tick(n);
        go <= 1'h0;
        do tick(n);
        while (!far_u.rc[7] || !far_u.tc[7] || rx_data_valid_out || st_q);
        tick(n);
    endtask
    task automatic rx_case(input logic [31:0] ctl, input logic [31:0] m);
        int k = 0;
        axw(TDMCS_OFF_RCE, m, TDMCS_RESP_OKAY);
        axw(TDMCS_OFF_CTL, ctl, TDMCS_RESP_OKAY);
        frame(1'h0);
        for (int c = 0; c < 128; c++) begin
            if (!ctl[0] || pick(c, ctl[6:5], ctl[8:7], m, ctl[9] && ctl[25])) begin
                check(got[k], {24'hC35A96, 8'(c)});
                k++;
            end
        end
        check(got.size(), k);
        axr(TDMCS_OFF_CTL, ctl & 32'h03E3_03E1 | 32'h001C_001C, TDMCS_RESP_OKAY);
    endtask
    task automatic tx_case(input logic [1:0] md);
        logic [31:0] ctl;
        logic sx, sr;
        logic [1:0] e;
        ctl = {7'h0, ~md, md, 3'h0, md, 7'h0, 2'h2, 2'h1, 5'h01};
        axw(TDMCS_OFF_CTL, ctl, TDMCS_RESP_OKAY);
        frame(md[0]);
        for (int c = 0; c < 128; c++) begin
            sx = pick(c, md, ~md, XM, 1'h0);
            sr = pick(c, 2'h1, 2'h2, RM, 1'h0);
            case (md)
                2'h0: e = 2'h3;
                2'h1: e = {sx, sx};
                2'h2: e = {sx, 1'h1};
                default: e = {sr && XM[c % 32], sr};
            endcase
            check(txg[c], {30'h0, e});
        end
    endtask
    // Main sequence: reset, register map, receive gating, then every transmit mode.
    initial begin
        int n;
        repeat (20) @(posedge clk_sys_in);
        resetn_in <= 1'h1;
        repeat (4) @(posedge clk_sys_in);
        for (int i = 0; i < 3; i++) axr(32'(4 * i), 32'h0, TDMCS_RESP_OKAY);
        axw(32'hC, 32'hFFFF_FFFF, TDMCS_RESP_SLVERR);
        axr(32'hC, 32'h0, TDMCS_RESP_SLVERR);
        axw(TDMCS_OFF_CTL, 32'hFFFF_FFFF, TDMCS_RESP_OKAY);
        axr(TDMCS_OFF_CTL, 32'h03E3_03E1, TDMCS_RESP_OKAY);
        for (int k = 0; k < 4; k++) rx_case({23'h0, 2'(3 - k), 2'(k), 5'h01}, RM >> k);
        rx_case(32'h0000_0060, 32'h0);
        rx_case(32'h0200_0201, 32'h8001_7FFE);
        rx_case(32'h0000_0201, 32'h8001_7FFE);
        tx_frame_active_in <= 1'h1;
        axw(TDMCS_OFF_RCE, RM, TDMCS_RESP_OKAY);
        axw(TDMCS_OFF_XCE, XM, TDMCS_RESP_OKAY);
        axr(TDMCS_OFF_XCE, XM, TDMCS_RESP_OKAY);
        for (int m = 0; m < 4; m++) tx_case(2'(m));
        tx_frame_active_in <= 1'h0;
        repeat (3) tick(n);
        check(serial_data_out_oe_out, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
